// [khi_kbd_model.sv]
// Keyboard and mouse side of the serial link, at byte level.
// Assumes the bench calls send and sets ack_delay while it runs.
module khi_kbd_model (
    input  wire logic       clk_i,       // Controller clock.
    input  wire logic       rx_ready_i,  // Controller can take a byte.
    output logic            rx_valid_o,  // Byte offered.
    output logic [7:0]      rx_data_o,   // Offered byte.
    output logic            rx_parity_o, // Parity bit of the byte.
    output logic            rx_aux_o,    // Byte comes from the mouse.
    input  wire logic       tx_valid_i,  // Controller sends a byte.
    input  wire logic [7:0] tx_data_i,   // Byte sent to the keyboard.
    output logic            tx_ack_o     // Acknowledge pulse.
);
    timeunit 1ns;
    timeprecision 100ps;
    int         ack_delay = 3;  // Cycles before acknowledging; -1 never.
    int         tx_cnt    = 0;  // Bytes seen from the controller.
    int         overlap   = 0;  // Sends while a byte was unacknowledged.
    logic       busy      = 0;  // A sent byte waits for its acknowledge.
    logic [7:0] tx_last   = 8'h00; // Last byte seen.

    initial begin
        rx_valid_o = 0;
        rx_data_o = 8'h00;
        rx_parity_o = 0;
        rx_aux_o = 0;
        tx_ack_o = 0;
    end

    // Offers one byte with odd or broken parity until the FIFO takes it.
    task automatic send(input logic [7:0] d, input logic aux, input logic bad);
        @(negedge clk_i);
        rx_valid_o = 1;
        rx_data_o = d;
        rx_parity_o = ~^d ^ bad;
        rx_aux_o = aux;
        do @(posedge clk_i); while (rx_ready_i !== 1'b1);
        @(negedge clk_i);
        rx_valid_o = 0;
        rx_data_o = ~d; // Released lines must not keep the old byte.
        rx_parity_o = ~rx_parity_o;
    endtask

    // Logs each byte sent and notes a send before the last acknowledge.
    always @(posedge clk_i) begin
        if (tx_valid_i === 1'b1) begin
            if (busy) overlap++;
            busy = 1;
            tx_cnt++;
            tx_last = tx_data_i;
        end
    end

    // Acknowledges the pending byte after the chosen delay, unless the delay is -1.
    initial forever begin
        @(posedge clk_i);
        if (busy && ack_delay >= 0) begin
            repeat (ack_delay) @(posedge clk_i);
            @(negedge clk_i);
            tx_ack_o = 1;
            busy = 0;
            @(negedge clk_i);
            tx_ack_o = 0;
        end
    end
endmodule

// [khi_pkg.sv]
// Constants shared by the keyboard host interface block.
// Assumes a 40 MHz controller clock and byte-wide host I/O ports.
package khi_pkg;

    // Default host I/O port addresses after reset.
    localparam logic [15:0] KHI_DATA_ADDR_RST = 16'h0060;
    localparam logic [15:0] KHI_CMD_ADDR_RST  = 16'h0064;

    // Status register bit positions.
    localparam int KHI_ST_OBF  = 0;
    localparam int KHI_ST_IBF  = 1;
    localparam int KHI_ST_SYS  = 2;
    localparam int KHI_ST_CMD  = 3;
    localparam int KHI_ST_INH  = 4;
    localparam int KHI_ST_AUX  = 5;
    localparam int KHI_ST_TOUT = 6;
    localparam int KHI_ST_PERR = 7;

    // Configuration byte bit positions.
    localparam int KHI_CF_KIRQ = 0;
    localparam int KHI_CF_AIRQ = 1;
    localparam int KHI_CF_SYS  = 2;
    localparam int KHI_CF_KDIS = 4;
    localparam int KHI_CF_ADIS = 5;
    localparam int KHI_CF_XLAT = 6;

    // Configuration byte value after reset.
    localparam logic [7:0] KHI_CFG_RST = 8'h00;

    // Host commands and their answers.
    localparam logic [7:0] KHI_CMD_RD_CFG  = 8'h20;
    localparam logic [7:0] KHI_CMD_WR_CFG  = 8'h60;
    localparam logic [7:0] KHI_CMD_PW_TEST = 8'ha4;
    localparam logic [7:0] KHI_PW_LOADED   = 8'hfa;
    localparam logic [7:0] KHI_PW_NONE     = 8'hf1;

    // Acknowledge time-out for bytes sent to the keyboard.
    localparam int KHI_CLK_MHZ    = 40;
    localparam int KHI_ACK_TO_US  = 2;
    localparam int KHI_ACK_TO_CYC = KHI_ACK_TO_US * KHI_CLK_MHZ;

    // Controller sequencer states, Gray coded.
    typedef enum logic [1:0] {
        KHI_ST_IDLE = 2'b00,
        KHI_ST_RESP = 2'b01,
        KHI_ST_ACKW = 2'b11
    } khi_state_type;

endpackage

// [khi_top.sv]
// Keyboard host interface: host I/O ports, received-byte FIFO,
// command byte and the read/write/password-test commands.
// Assumes the serial receive/transmit logic and the host bus run
// on SYS_CLK_I; only the inhibit pin is asynchronous.
// Overview of operation
// - Received bytes are parity checked and placed in the output buffer.
// - Loading the output buffer raises an interrupt if enabled.
// - No new byte goes to the keyboard before the previous is acknowledged or times out.
// - Output buffer is a read-only byte at relocatable data address.
// - Input buffer is a write-only byte at data and command addresses.
// - Data address marks data, command address marks command, status bit 3.
// - Data bytes go to keyboard unless a parameter is awaited.
// - Status register is readable any time at the command address.
// - Status bits 0 and 1 show output and input buffer full.
// - Status bit 2 mirrors the configuration system flag, zero at reset.
// - Status bit 4 is one when the keyboard is not inhibited.
// - Status bit 5 is one when the buffered byte came from the mouse.
// - Status bit 6 reports an acknowledge time-out.
// - Status bit 7 is one when the last byte had even parity.
// - Command 20h returns the configuration byte in the output buffer.
// - Command 60h takes the next data byte as configuration byte.
// - Config bits: translate, mouse disable, keyboard disable, system flag.
// - Config bits 0 and 1 enable keyboard and mouse interrupts.
// - Command A4h returns FAh if a password is loaded, else F1h.

// Synchronous FIFO with registered input-side ready.
module khi_fifo
    import khi_pkg::*;
#(
    parameter int W = 10,
    parameter int D = 16
) (
    input  wire logic         clk_i,     // Controller clock.
    input  wire logic         rst_i,     // Synchronous reset.
    input  wire logic         in_valid_i, // Write request.
    output logic              in_ready_o, // Room available.
    input  wire logic [W-1:0] in_data_i, // Write data.
    output logic              out_valid_o, // Word available.
    input  wire logic         out_ready_i, // Read request.
    output logic [W-1:0]      out_data_o // Head word.
);
    localparam int AW = $clog2(D);
    if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
        $error("khi_fifo depth must be a power of two");
    end
    logic [W-1:0] mem_reg [D];
    logic [AW-1:0] wp_reg, rp_reg;
    logic [AW:0]   cnt_reg;
    logic [AW:0]   cnt_next;
    logic          push, pop;
    // Handshakes on both sides.
    assign push = in_valid_i && in_ready_o;
    assign pop  = out_valid_o && out_ready_i;
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o  = mem_reg[rp_reg];
    // Next fill level; a push and a pop together leave it unchanged.
    assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    // Pointers, level and ready flag.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wp_reg     <= '0;
            rp_reg     <= '0;
            cnt_reg    <= '0;
            in_ready_o <= 1'b1;
        end else begin
            if (push) wp_reg <= wp_reg + 1'b1;
            if (pop) rp_reg <= rp_reg + 1'b1;
            cnt_reg    <= cnt_next;
            in_ready_o <= (cnt_next < (AW+1)'(D));
        end
    end
    // Storage array.
    always_ff @(posedge clk_i) begin
        if (push) mem_reg[wp_reg] <= in_data_i;
    end
endmodule

// Host-facing controller logic.
module khi_top
    import khi_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input  wire logic        SYS_CLK_I,   // Controller clock.
    input  wire logic        RST_I,       // Synchronous reset.
    input  wire logic [15:0] IO_ADDR_I,   // Host I/O address.
    input  wire logic        IO_WR_I,     // Host write strobe.
    input  wire logic        IO_RD_I,     // Host read strobe.
    input  wire logic [7:0]  IO_WDATA_I,  // Host write data.
    output logic [7:0]       IO_RDATA_O,  // Host read data.
    input  wire logic        CFG_LD_I,    // Load new port addresses.
    input  wire logic [15:0] CFG_DATA_ADDR_I, // New data address.
    input  wire logic [15:0] CFG_CMD_ADDR_I,  // New command address.
    input  wire logic        RX_VALID_I,  // Received byte valid.
    output logic             RX_READY_O,  // FIFO can take a byte.
    input  wire logic [7:0]  RX_DATA_I,   // Received byte.
    input  wire logic        RX_PARITY_I, // Received parity bit.
    input  wire logic        RX_AUX_I,    // Byte is from the mouse.
    output logic             TX_VALID_O,  // Send byte pulse.
    output logic [7:0]       TX_DATA_O,   // Byte to keyboard.
    input  wire logic        TX_ACK_I,    // Keyboard acknowledge.
    input  wire logic        KBD_INHIBIT_N_I, // Inhibit pin, low.
    input  wire logic        PW_LOADED_I, // Password is loaded.
    output logic             KBD_IRQ_O,   // Keyboard interrupt.
    output logic             AUX_IRQ_O,   // Mouse interrupt.
    output logic             XLATE_O      // Translation enabled.
);
    localparam int FW = 10;
    khi_state_type state_reg;
    logic [15:0] daddr_reg;
    logic [15:0] caddr_reg;
    logic        inh_s1_reg, inh_s2_reg;
    logic [7:0]  ib_reg;
    logic        ibf_reg;
    logic        cmdf_reg;
    logic [7:0]  cfg_reg;
    logic        pwait_reg;
    logic [7:0]  resp_reg;
    logic [7:0]  ob_reg;
    logic        obf_reg;
    logic        aux_reg;
    logic        perr_reg;
    logic        tout_reg;
    logic [$clog2(KHI_ACK_TO_CYC+1)-1:0] ackc_reg;
    logic [7:0]  status;
    logic        wr_d, wr_c, rd_d, rd_c;
    logic        consume;
    logic        cfg_we;
    logic        tx_start;
    logic        ack_to;
    logic        load_resp, load_rx, push_v, f_valid;
    logic [FW-1:0] f_data;
    logic        ob_full_next, aux_next;
    // Address decode of the host strobes.
    assign wr_d = IO_WR_I && (IO_ADDR_I == daddr_reg);
    assign wr_c = IO_WR_I && (IO_ADDR_I == caddr_reg);
    assign rd_d = IO_RD_I && (IO_ADDR_I == daddr_reg);
    assign rd_c = IO_RD_I && (IO_ADDR_I == caddr_reg);
    // Status register assembly.
    always_comb begin
        status = 8'h00;
        status[KHI_ST_OBF]  = obf_reg;
        status[KHI_ST_IBF]  = ibf_reg;
        status[KHI_ST_SYS]  = cfg_reg[KHI_CF_SYS];
        status[KHI_ST_CMD]  = cmdf_reg;
        status[KHI_ST_INH]  = inh_s2_reg;
        status[KHI_ST_AUX]  = aux_reg;
        status[KHI_ST_TOUT] = tout_reg;
        status[KHI_ST_PERR] = perr_reg;
    end
    // Port addresses reset to defaults and may be relocated.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            daddr_reg <= KHI_DATA_ADDR_RST;
            caddr_reg <= KHI_CMD_ADDR_RST;
        end else if (CFG_LD_I) begin
            daddr_reg <= CFG_DATA_ADDR_I;
            caddr_reg <= CFG_CMD_ADDR_I;
        end
    end
    // Two-stage synchroniser for the inhibit pin.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            inh_s1_reg <= 1'b1;
            inh_s2_reg <= 1'b1;
        end else begin
            inh_s1_reg <= KBD_INHIBIT_N_I;
            inh_s2_reg <= inh_s1_reg;
        end
    end
    // Input buffer: a write while full is ignored.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ib_reg   <= 8'h00;
            ibf_reg  <= 1'b0;
            cmdf_reg <= 1'b0;
        end else if ((wr_d || wr_c) && !ibf_reg) begin
            ib_reg   <= IO_WDATA_I;
            ibf_reg  <= 1'b1;
            cmdf_reg <= wr_c;
        end else if (consume) begin
            ibf_reg  <= 1'b0;
        end
    end
    // Sequencer decisions for the byte in the input buffer.
    assign consume  = (state_reg == KHI_ST_IDLE) && ibf_reg;
    assign cfg_we   = consume && !cmdf_reg && pwait_reg;
    assign tx_start = consume && !cmdf_reg && !pwait_reg;
    assign ack_to   = (state_reg == KHI_ST_ACKW) && !TX_ACK_I
                      && (ackc_reg == KHI_ACK_TO_CYC - 1);
    // Command sequencer.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            state_reg <= KHI_ST_IDLE;
            pwait_reg <= 1'b0;
            resp_reg  <= 8'h00;
        end else begin
            case (state_reg)
                KHI_ST_IDLE: begin
                    if (consume && cmdf_reg) begin
                        case (ib_reg)
                            KHI_CMD_RD_CFG: begin
                                resp_reg  <= cfg_reg;
                                state_reg <= KHI_ST_RESP;
                            end
                            KHI_CMD_PW_TEST: begin
                                resp_reg  <= PW_LOADED_I ?
                                    KHI_PW_LOADED : KHI_PW_NONE;
                                state_reg <= KHI_ST_RESP;
                            end
                            KHI_CMD_WR_CFG: pwait_reg <= 1'b1;
                            default: pwait_reg <= 1'b0;
                        endcase
                    end else if (cfg_we) begin
                        pwait_reg <= 1'b0;
                    end else if (tx_start) begin
                        state_reg <= KHI_ST_ACKW;
                    end
                end
                KHI_ST_RESP: begin
                    if (load_resp) state_reg <= KHI_ST_IDLE;
                end
                KHI_ST_ACKW: begin
                    if (TX_ACK_I || ack_to) begin
                        state_reg <= KHI_ST_IDLE;
                    end
                end
                default: state_reg <= KHI_ST_IDLE;
            endcase
        end
    end
    // Configuration byte.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            cfg_reg <= KHI_CFG_RST;
        end else if (cfg_we) begin
            cfg_reg <= ib_reg;
        end
    end
    // Transmit pulse and acknowledge wait counter.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            TX_VALID_O <= 1'b0;
            TX_DATA_O  <= 8'h00;
            ackc_reg   <= '0;
        end else begin
            TX_VALID_O <= tx_start;
            if (tx_start) TX_DATA_O <= ib_reg;
            ackc_reg <= (state_reg == KHI_ST_ACKW) ? ackc_reg + 1'b1 : '0;
        end
    end
    // Time-out flag, cleared when the next byte is sent.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            tout_reg <= 1'b0;
        end else if (ack_to) begin
            tout_reg <= 1'b1;
        end else if (tx_start) begin
            tout_reg <= 1'b0;
        end
    end
    // Received bytes from a disabled source are dropped.
    assign push_v = RX_VALID_I && !(RX_AUX_I ? cfg_reg[KHI_CF_ADIS]
                                             : cfg_reg[KHI_CF_KDIS]);
    khi_fifo #(
        .W (FW),
        .D (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (SYS_CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (push_v),
        .in_ready_o  (RX_READY_O),
        .in_data_i   ({RX_AUX_I, ~^{RX_DATA_I, RX_PARITY_I},
                       RX_DATA_I}),
        .out_valid_o (f_valid),
        .out_ready_i (load_rx),
        .out_data_o  (f_data)
    );
    // Responses take the output buffer before received bytes.
    assign load_resp = (state_reg == KHI_ST_RESP) && !obf_reg;
    assign load_rx   = !obf_reg && !load_resp && f_valid;
    // Next output buffer flags.
    always_comb begin
        ob_full_next = obf_reg;
        aux_next     = aux_reg;
        if (load_resp) begin
            ob_full_next = 1'b1;
            aux_next     = 1'b0;
        end else if (load_rx) begin
            ob_full_next = 1'b1;
            aux_next     = f_data[FW-1];
        end else if (rd_d) begin
            ob_full_next = 1'b0;
            aux_next     = 1'b0;
        end
    end
    // Output buffer, its flags and parity status.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            ob_reg   <= 8'h00;
            obf_reg  <= 1'b0;
            aux_reg  <= 1'b0;
            perr_reg <= 1'b0;
        end else begin
            obf_reg <= ob_full_next;
            aux_reg <= aux_next;
            if (load_resp) begin
                ob_reg <= resp_reg;
            end else if (load_rx) begin
                ob_reg   <= f_data[7:0];
                perr_reg <= f_data[8];
            end
        end
    end
    // Interrupt lines follow a full buffer and its source enable.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            KBD_IRQ_O <= 1'b0;
            AUX_IRQ_O <= 1'b0;
        end else begin
            KBD_IRQ_O <= ob_full_next && !aux_next
                         && cfg_reg[KHI_CF_KIRQ];
            AUX_IRQ_O <= ob_full_next && aux_next
                         && cfg_reg[KHI_CF_AIRQ];
        end
    end
    // Host read data and translation flag.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            IO_RDATA_O <= 8'h00;
            XLATE_O    <= 1'b0;
        end else begin
            XLATE_O <= cfg_reg[KHI_CF_XLAT];
            if (rd_d) begin
                IO_RDATA_O <= ob_reg;
            end else if (rd_c) begin
                IO_RDATA_O <= status;
            end else begin
                IO_RDATA_O <= 8'h00;
            end
        end
    end
    // Checks run on the controller clock and rest during reset.
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_param_byte;
        consume && !cmdf_reg && pwait_reg;
    endsequence
    sequence s_pw_cmd;
        consume && cmdf_reg && (ib_reg == KHI_CMD_PW_TEST);
    endsequence
    a_rx_to_obuf: assert property (
        load_rx |=> obf_reg && (ob_reg == $past(f_data[7:0])))
        else $error("received byte not loaded");
    a_kbd_irq: assert property (
        load_rx && !f_data[FW-1] && cfg_reg[KHI_CF_KIRQ]
        && !cfg_we |=> KBD_IRQ_O)
        else $error("keyboard interrupt missing");
    a_irq_enable: assert property (
        AUX_IRQ_O |-> $past(cfg_reg[KHI_CF_AIRQ]) && aux_reg)
        else $error("mouse interrupt without enable");
    a_tx_one_ack: assert property (
        TX_VALID_O |-> (state_reg == KHI_ST_ACKW)
        && ($past(state_reg) == KHI_ST_IDLE))
        else $error("byte sent while awaiting acknowledge");
    a_cmd_mark: assert property (
        wr_c && !ibf_reg |=> status[KHI_ST_CMD] && ibf_reg)
        else $error("command write not marked");
    a_rd_clears: assert property (
        rd_d && obf_reg |=> !aux_reg && (!obf_reg || $past(load_resp)))
        else $error("output buffer read did not clear");
    a_status_rd: assert property (
        rd_c && !rd_d |=> IO_RDATA_O == $past(status))
        else $error("status read mismatch");
    a_cfg_write: assert property (
        s_param_byte |=> cfg_reg == $past(ib_reg))
        else $error("configuration byte not written");
    a_pw_answer: assert property (
        s_pw_cmd |=> (resp_reg == ($past(PW_LOADED_I) ?
            KHI_PW_LOADED : KHI_PW_NONE)) && (state_reg == KHI_ST_RESP))
        else $error("password test answer wrong");
    a_ack_tout: assert property (
        ack_to |=> tout_reg && (state_reg == KHI_ST_IDLE))
        else $error("acknowledge time-out not flagged");
    a_parity: assert property (
        load_rx |=> status[KHI_ST_PERR] == $past(f_data[8]))
        else $error("parity status wrong");
endmodule

// [testbench.sv]
// Self-checking bench for the keyboard host interface.
// Assumes khi_pkg, khi_top and khi_kbd_model are compiled first.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import khi_pkg::*;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, cld = 0;
    logic        inh_n = 1, pw = 0;
    logic [15:0] addr = 16'h0000, da = KHI_DATA_ADDR_RST;
    logic [15:0] ca = KHI_CMD_ADDR_RST, nda = 16'h0160, nca = 16'h0164;
    logic [7:0]  wdata = 8'h00, rdata, tx_data, rx_data, s;
    logic        rx_valid, rx_ready, rx_par, rx_aux, tx_valid, tx_ack;
    logic        kirq, airq, xlat;
    int          err_total = 0, tests_run = 0, tn = 0;

    always #12.5 clk = ~clk;

    khi_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .IO_ADDR_I(addr),
        .IO_WR_I(wr), .IO_RD_I(rd), .IO_WDATA_I(wdata), .IO_RDATA_O(rdata),
        .CFG_LD_I(cld), .CFG_DATA_ADDR_I(nda), .CFG_CMD_ADDR_I(nca),
        .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready), .RX_DATA_I(rx_data),
        .RX_PARITY_I(rx_par), .RX_AUX_I(rx_aux), .TX_VALID_O(tx_valid),
        .TX_DATA_O(tx_data), .TX_ACK_I(tx_ack), .KBD_INHIBIT_N_I(inh_n),
        .PW_LOADED_I(pw), .KBD_IRQ_O(kirq), .AUX_IRQ_O(airq),
        .XLATE_O(xlat));

    khi_kbd_model kbd_u (.clk_i(clk), .rx_ready_i(rx_ready),
        .rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_parity_o(rx_par),
        .rx_aux_o(rx_aux), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
        .tx_ack_o(tx_ack));

    // Counts one comparison and reports a mismatch.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Host bus write and read, one strobe cycle each.
    task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1;
        @(negedge clk);
        rd = 0;
        d = rdata;
    endtask

    // Polls status until the masked bits match, within a bound.
    task automatic wait_st(input logic [7:0] m, input logic [7:0] v);
        logic [7:0] t;
        int n;
        n = 0;
        do begin
            io_rd(ca, t);
            n++;
        end while ((t & m) !== v && n < 300);
        check(t & m, v);
    endtask

    // Writes a command or a data byte once the input buffer is empty.
    task automatic cmd(input logic [7:0] c);
        wait_st(8'h02, 8'h00);
        io_wr(ca, c);
    endtask
    task automatic wdat(input logic [7:0] d);
        wait_st(8'h02, 8'h00);
        io_wr(da, d);
    endtask

    // Waits for a full output buffer and reads it.
    task automatic getob(input logic [7:0] exp);
        logic [7:0] t;
        wait_st(8'h01, 8'h01);
        io_rd(da, t);
        check(t, exp);
    endtask

    task automatic tdone();
        tn++;
        $display("Test %0d done", tn);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        results();
    end

    // Main sequence of tests.
    initial begin
        repeat (2) @(negedge clk);
        rst = 0;
        io_rd(ca, s);
        check(s, 8'h10);
        check({4'h0, kirq, airq, xlat, rx_ready}, 8'h01);
        tdone();
        cmd(KHI_CMD_RD_CFG);
        wait_st(8'h0b, 8'h09);
        getob(KHI_CFG_RST);
        io_rd(ca, s);
        check(s & 8'h21, 8'h00);
        tdone();
        cmd(KHI_CMD_WR_CFG);
        wdat(8'h47);
        wait_st(8'h0e, 8'h04);
        check({7'h0, xlat}, 8'h01);
        check(8'(kbd_u.tx_cnt), 8'h00);
        cmd(KHI_CMD_RD_CFG);
        getob(8'h47);
        tdone();
        kbd_u.send(8'h1c, 0, 0);
        wait_st(8'hf1, 8'h11);
        check({6'h0, kirq, airq}, 8'h02);
        getob(8'h1c);
        check({6'h0, kirq, airq}, 8'h00);
        kbd_u.send(8'h5a, 1, 1);
        wait_st(8'hf1, 8'hb1);
        check({6'h0, kirq, airq}, 8'h01);
        getob(8'h5a);
        tdone();
        cmd(KHI_CMD_WR_CFG);
        wdat(8'h10);
        kbd_u.send(8'h11, 0, 0);
        kbd_u.send(8'h22, 1, 0);
        wait_st(8'h21, 8'h21);
        check({6'h0, kirq, airq}, 8'h00);
        getob(8'h22);
        tdone();
        cmd(KHI_CMD_WR_CFG);
        wdat(8'h20);
        kbd_u.send(8'h33, 1, 0);
        kbd_u.send(8'h44, 0, 0);
        wait_st(8'h21, 8'h01);
        getob(8'h44);
        tdone();
        cmd(KHI_CMD_WR_CFG);
        wdat(8'h03);
        for (int i = 0; i < 17; i++) kbd_u.send(8'h80 + 8'(i), 0, 0);
        repeat (3) @(negedge clk);
        check({7'h0, rx_ready}, 8'h00);
        for (int i = 0; i < 17; i++) getob(8'h80 + 8'(i));
        tdone();
        kbd_u.ack_delay = 20;
        wdat(8'h55);
        wait (kbd_u.tx_cnt == 1);
        check(kbd_u.tx_last, 8'h55);
        wdat(8'haa);
        wait (kbd_u.tx_cnt == 2);
        check(kbd_u.tx_last, 8'haa);
        check(8'(kbd_u.overlap), 8'h00);
        tdone();
        for (int p = 0; p < 2; p++) begin
            pw = p[0];
            cmd(KHI_CMD_PW_TEST);
            getob(p[0] ? KHI_PW_LOADED : KHI_PW_NONE);
        end
        cmd(8'hee);
        wait_st(8'h0b, 8'h08);
        tdone();
        io_rd(16'h0070, s);
        check(s, 8'h00);
        @(negedge clk);
        cld = 1;
        @(negedge clk);
        cld = 0;
        io_rd(ca, s);
        check(s, 8'h00);
        da = nda;
        ca = nca;
        cmd(KHI_CMD_RD_CFG);
        getob(8'h03);
        tdone();
        inh_n = 0;
        repeat (4) @(negedge clk);
        io_rd(ca, s);
        check(s & 8'h10, 8'h00);
        inh_n = 1;
        tdone();
        kbd_u.ack_delay = -1;
        wdat(8'h33);
        wait_st(8'h40, 8'h40);
        kbd_u.ack_delay = 2;
        kbd_u.busy = 0;
        wdat(8'h34);
        wait_st(8'h40, 8'h00);
        tdone();
        @(negedge clk);
        rst = 1;
        repeat (2) @(negedge clk);
        rst = 0;
        da = KHI_DATA_ADDR_RST;
        ca = KHI_CMD_ADDR_RST;
        io_rd(ca, s);
        check(s, 8'h10);
        check({4'h0, kirq, airq, xlat, rx_ready}, 8'h01);
        tdone();
        results();
    end
endmodule
